/* logic/wsvrf_pkg.sv */
// Shared constants, types and helpers for the wide vector register file
package wsvrf_pkg;

  localparam int VEC_W  = 128;
  localparam int NUM_VEC = 16;
  localparam int IDX_W  = 4;
  localparam int SEL_W  = 3;
  localparam int LANE_W = 32;
  localparam int QW_W   = 64;
  localparam int NBYTES = 16;
  localparam int BYTE_W = 8;
  localparam int MM_NUM = 8;
  localparam int MM_W   = 64;
  localparam int EA_W   = 64;
  localparam int DISP_W = 32;

  // Control/status register
  localparam int                CSR_W       = 32;
  localparam logic [CSR_W-1:0]  CSR_RST     = 32'h0000_1F80;
  localparam int                CSR_RSVD_LO = 16;
  localparam int                CSR_FLAG_W  = 6;

  // Feature identification
  localparam int                SIMD_FEAT_BIT = 25;
  localparam logic [31:0]       FEAT_LEAF     = 32'h0000_0001;

  // Arithmetic flags register
  localparam logic [31:0] FLAGS_RST = 32'h0000_0002;
  localparam int FLG_CF = 0;
  localparam int FLG_PF = 2;
  localparam int FLG_AF = 4;
  localparam int FLG_ZF = 6;
  localparam int FLG_SF = 7;
  localparam int FLG_OF = 11;

  // Byte enables per transfer size
  localparam logic [NBYTES-1:0] BE32  = 16'h000F;
  localparam logic [NBYTES-1:0] BE64  = 16'h00FF;
  localparam logic [NBYTES-1:0] BE128 = 16'hFFFF;

  typedef enum logic [2:0] {
    WSVRF_REAL, WSVRF_V86, WSVRF_PROT, WSVRF_COMPAT, WSVRF_LONG64
  } wsvrf_mode_type;

  typedef enum logic [1:0] {
    WSVRF_SZ32, WSVRF_SZ64, WSVRF_SZ128
  } wsvrf_size_type;

  // Extension bit counts only in 64-bit mode with a prefix present
  function automatic logic [IDX_W-1:0] eff_idx(
    input wsvrf_mode_type mode,
    input logic           register_extension_prefix,
    input logic           ext,
    input logic [SEL_W-1:0] sel);
    eff_idx = {(mode == WSVRF_LONG64) & register_extension_prefix & ext, sel};
  endfunction

  function automatic logic [NBYTES-1:0] size_be(input wsvrf_size_type sz);
    case (sz)
      WSVRF_SZ32: size_be = BE32;
      WSVRF_SZ64: size_be = BE64;
      default:    size_be = BE128;
    endcase
  endfunction

  function automatic logic [VEC_W-1:0] be_bits(input logic [NBYTES-1:0] be);
    be_bits = '0;
    for (int i = 0; i < NBYTES; i++) begin
      be_bits[i*BYTE_W +: BYTE_W] = {BYTE_W{be[i]}};
    end
  endfunction

endpackage

/* logic/wsvrf_pir.sv */
// Packed-integer register file, storage separate from the vector file
`timescale 1ns/1ps
module wsvrf_pir (
  input  wire logic                       clk_i,
  input  wire logic                       sys_rst_i,
  input  wire logic                       wr_en_i,
  input  wire logic [wsvrf_pkg::SEL_W-1:0] wr_sel_i,
  input  wire logic [wsvrf_pkg::MM_W-1:0]  wr_data_i,
  input  wire logic [wsvrf_pkg::SEL_W-1:0] rd_sel_i,
  output logic      [wsvrf_pkg::MM_W-1:0]  rd_data_o
);

  typedef struct packed {
    logic [wsvrf_pkg::MM_NUM-1:0][wsvrf_pkg::MM_W-1:0] mm;
  } wsvrf_pir_type;

  wsvrf_pir_type q;
  wsvrf_pir_type next_q;

  // Single write port, no bypass: readers see the settled value
  always_comb begin
    next_q = q;
    if (wr_en_i) begin
      next_q.mm[wr_sel_i] = wr_data_i;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign rd_data_o = q.mm[rd_sel_i];

endmodule

/* logic/wsvrf_top.sv */
// Wide vector register file with control/status, flags and store port
`timescale 1ns/1ps
// What this block does
// - Feature leaf one sets presence bit 25
// - Eight registers, sixteen in 64-bit mode
// - Upper eight need extension prefix bit
// - Compatibility mode behaves as protected mode
// - Scalar ops use low 32-bit lane
// - Vector storage independent of other registers
// - Addresses formed from general registers only
// - Transfers at 32, 64, 128 bit widths
// - Full store: sixteen bytes, low byte first
// - Meaningless extension prefix is simply ignored
// - Width bit selects 64-bit general registers
// - 32-bit control/status register governs operations
// - Compares write result into flags register
// - Usable in real, protected, v86 modes
// - Packed-integer registers exchange operands with vectors
// - Reserved control bits zero; nonzero faults
module wsvrf_top (
  input  wire logic                          clk_i,
  input  wire logic                          sys_rst_i,
  input  wire wsvrf_pkg::wsvrf_mode_type     mode_i,
  input  wire logic                          rex_i,
  input  wire logic                          operand_width_prefix_bit_i,
  input  wire logic [wsvrf_pkg::SEL_W-1:0]   rd_a_sel_i,
  input  wire logic                          rd_a_ext_i,
  input  wire logic [wsvrf_pkg::SEL_W-1:0]   rd_b_sel_i,
  input  wire logic                          rd_b_ext_i,
  output logic      [wsvrf_pkg::VEC_W-1:0]   rd_a_o,
  output logic      [wsvrf_pkg::VEC_W-1:0]   rd_b_o,
  input  wire logic                          wr_en_i,
  input  wire logic [wsvrf_pkg::SEL_W-1:0]   wr_sel_i,
  input  wire logic                          wr_ext_i,
  input  wire wsvrf_pkg::wsvrf_size_type     wr_size_i,
  input  wire logic                          wr_zero_upper_i,
  input  wire logic                          wr_src_mm_i,
  input  wire logic [wsvrf_pkg::VEC_W-1:0]   wr_data_i,
  input  wire logic                          st_req_i,
  input  wire logic [wsvrf_pkg::SEL_W-1:0]   st_sel_i,
  input  wire logic                          st_ext_i,
  input  wire wsvrf_pkg::wsvrf_size_type     st_size_i,
  output logic                               st_valid_o,
  output logic      [wsvrf_pkg::VEC_W-1:0]   st_data_o,
  output logic      [wsvrf_pkg::NBYTES-1:0]  st_be_o,
  input  wire logic                          mm_wr_i,
  input  wire logic [wsvrf_pkg::SEL_W-1:0]   mm_sel_i,
  input  wire logic                          csr_wr_i,
  input  wire logic [wsvrf_pkg::CSR_W-1:0]   csr_wr_data_i,
  input  wire logic [wsvrf_pkg::CSR_FLAG_W-1:0] fp_flags_set_i,
  output logic      [wsvrf_pkg::CSR_W-1:0]   csr_o,
  output logic                               gp_fault_o,
  input  wire logic                          cmp_valid_i,
  input  wire logic                          cmp_zf_i,
  input  wire logic                          cmp_pf_i,
  input  wire logic                          cmp_cf_i,
  output logic      [31:0]                   flags_o,
  input  wire logic                          feat_req_i,
  input  wire logic [31:0]                   feat_leaf_i,
  output logic      [31:0]                   feat_d_o,
  output logic                               gpr_w64_o,
  input  wire logic [wsvrf_pkg::EA_W-1:0]    ea_base_i,
  input  wire logic [wsvrf_pkg::EA_W-1:0]    ea_index_i,
  input  wire logic [1:0]                    ea_scale_i,
  input  wire logic [wsvrf_pkg::DISP_W-1:0]  ea_disp_i,
  output logic      [wsvrf_pkg::EA_W-1:0]    ea_o
);

  localparam int VW = wsvrf_pkg::VEC_W;
  localparam int QW = wsvrf_pkg::QW_W;

  typedef struct packed {
    logic [wsvrf_pkg::NUM_VEC-1:0][VW-1:0] vec;
    logic [VW-1:0]                         rd_a;
    logic [VW-1:0]                         rd_b;
    logic [VW-1:0]                         st_data;
    logic [wsvrf_pkg::NBYTES-1:0]          st_be;
    logic                                  st_valid;
    logic [wsvrf_pkg::CSR_W-1:0]           csr;
    logic                                  gp_fault;
    logic [31:0]                           flags;
    logic [31:0]                           feat_d;
    logic                                  gpr_w64;
    logic [wsvrf_pkg::EA_W-1:0]            ea;
  } wsvrf_state_type;

  wsvrf_state_type q;
  wsvrf_state_type next_q;

  logic [wsvrf_pkg::IDX_W-1:0] a_idx;
  logic [wsvrf_pkg::IDX_W-1:0] b_idx;
  logic [wsvrf_pkg::IDX_W-1:0] w_idx;
  logic [wsvrf_pkg::IDX_W-1:0] s_idx;
  logic [wsvrf_pkg::MM_W-1:0]  mm_rd;
  logic [VW-1:0]               w_src;
  logic [VW-1:0]               w_mask;

  // Extension bit dropped outside 64-bit mode or without prefix
  assign a_idx = wsvrf_pkg::eff_idx(mode_i, rex_i, rd_a_ext_i,
                                    rd_a_sel_i);
  assign b_idx = wsvrf_pkg::eff_idx(mode_i, rex_i, rd_b_ext_i,
                                    rd_b_sel_i);
  assign w_idx = wsvrf_pkg::eff_idx(mode_i, rex_i, wr_ext_i,
                                    wr_sel_i);
  assign s_idx = wsvrf_pkg::eff_idx(mode_i, rex_i, st_ext_i,
                                    st_sel_i);

  // Write source: execution result or a packed-integer register
  assign w_src  = wr_src_mm_i ? {{QW{1'b0}}, mm_rd} : wr_data_i;
  assign w_mask = wsvrf_pkg::be_bits(wsvrf_pkg::size_be(wr_size_i));

  // Packed-integer file; vector low quadword is the move source
  wsvrf_pir u_pir (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .wr_en_i   (mm_wr_i),
    .wr_sel_i  (mm_sel_i),
    .wr_data_i (q.vec[a_idx][QW-1:0]),
    .rd_sel_i  (mm_sel_i),
    .rd_data_o (mm_rd)
  );

  // Next state; reads see this cycle's write, so no stall on RAW
  always_comb begin
    next_q = q;
    // Scalar and narrow writes keep untouched lanes unless zeroing
    if (wr_en_i) begin
      if (wr_zero_upper_i) begin
        next_q.vec[w_idx] = w_src & w_mask;
      end else begin
        next_q.vec[w_idx] = (q.vec[w_idx] & ~w_mask) |
                            (w_src & w_mask);
      end
    end
    next_q.rd_a = next_q.vec[a_idx];
    next_q.rd_b = next_q.vec[b_idx];
    // Store lanes: byte i of data is byte i of register
    next_q.st_valid = st_req_i;
    if (st_req_i) begin
      next_q.st_data = next_q.vec[s_idx];
      next_q.st_be   = wsvrf_pkg::size_be(st_size_i);
    end
    // Reserved bits must stay zero; offending load is refused
    next_q.gp_fault = 1'b0;
    if (csr_wr_i) begin
      if (csr_wr_data_i[wsvrf_pkg::CSR_W-1:wsvrf_pkg::CSR_RSVD_LO]
          != '0) begin
        next_q.gp_fault = 1'b1;
      end else begin
        next_q.csr = csr_wr_data_i;
      end
    end
    // Sticky flags: a set in the same cycle beats a clearing load
    next_q.csr[wsvrf_pkg::CSR_FLAG_W-1:0] =
      next_q.csr[wsvrf_pkg::CSR_FLAG_W-1:0] | fp_flags_set_i;
    // Compare outcome: ZF PF CF set, OF SF AF cleared
    if (cmp_valid_i) begin
      next_q.flags[wsvrf_pkg::FLG_ZF] = cmp_zf_i;
      next_q.flags[wsvrf_pkg::FLG_PF] = cmp_pf_i;
      next_q.flags[wsvrf_pkg::FLG_CF] = cmp_cf_i;
      next_q.flags[wsvrf_pkg::FLG_OF] = 1'b0;
      next_q.flags[wsvrf_pkg::FLG_SF] = 1'b0;
      next_q.flags[wsvrf_pkg::FLG_AF] = 1'b0;
    end
    // Feature word: only the presence bit is owned here
    if (feat_req_i) begin
      next_q.feat_d = '0;
      if (feat_leaf_i == wsvrf_pkg::FEAT_LEAF) begin
        next_q.feat_d[wsvrf_pkg::SIMD_FEAT_BIT] = 1'b1;
      end
    end
    // Width bit only has meaning with a prefix in 64-bit mode
    next_q.gpr_w64 = (mode_i == wsvrf_pkg::WSVRF_LONG64) &
                     rex_i & operand_width_prefix_bit_i;
    // Address path has no vector input at all
    next_q.ea = ea_base_i + (ea_index_i << ea_scale_i) +
                {{(wsvrf_pkg::EA_W-wsvrf_pkg::DISP_W){ea_disp_i[
                  wsvrf_pkg::DISP_W-1]}}, ea_disp_i};
  end

  // Mode only gates indexing and the width bit; no mode blocks access
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      q       <= '0;
      q.csr   <= wsvrf_pkg::CSR_RST;
      q.flags <= wsvrf_pkg::FLAGS_RST;
    end else begin
      q <= next_q;
    end
  end

  assign rd_a_o     = q.rd_a;
  assign rd_b_o     = q.rd_b;
  assign st_valid_o = q.st_valid;
  assign st_data_o  = q.st_data;
  assign st_be_o    = q.st_be;
  assign csr_o      = q.csr;
  assign gp_fault_o = q.gp_fault;
  assign flags_o    = q.flags;
  assign feat_d_o   = q.feat_d;
  assign gpr_w64_o  = q.gpr_w64;
  assign ea_o       = q.ea;

  // Checks
  chk_feat_bit: assert property (@(posedge clk_i)
    disable iff (sys_rst_i)
    feat_req_i |=> feat_d_o[wsvrf_pkg::SIMD_FEAT_BIT] ==
      ($past(feat_leaf_i) == wsvrf_pkg::FEAT_LEAF))
    else $error("presence bit wrong");

  chk_upper_hidden: assert property (@(posedge clk_i)
    disable iff (sys_rst_i)
    wr_en_i && mode_i != wsvrf_pkg::WSVRF_LONG64 |=>
      q.vec[{1'b1, $past(wr_sel_i)}] ==
      $past(q.vec[{1'b1, wr_sel_i}]))
    else $error("upper register written outside 64-bit mode");

  chk_read_fwd: assert property (@(posedge clk_i)
    disable iff (sys_rst_i)
    wr_en_i && !wr_src_mm_i && wr_size_i == wsvrf_pkg::WSVRF_SZ128 &&
    a_idx == w_idx |=> rd_a_o == $past(wr_data_i))
    else $error("read port missed forwarded write");

  chk_scalar_keep: assert property (@(posedge clk_i)
    disable iff (sys_rst_i)
    wr_en_i && !wr_zero_upper_i && wr_size_i == wsvrf_pkg::WSVRF_SZ32
    |=> q.vec[$past(w_idx)][VW-1:wsvrf_pkg::LANE_W] ==
        $past(q.vec[w_idx][VW-1:wsvrf_pkg::LANE_W]))
    else $error("scalar write touched upper lanes");

  // Whole register, byte for byte, so a lane swap cannot hide
  chk_store_order: assert property (@(posedge clk_i)
    disable iff (sys_rst_i)
    st_req_i && st_size_i == wsvrf_pkg::WSVRF_SZ128 |=>
      st_valid_o && st_be_o == wsvrf_pkg::BE128 &&
      st_data_o == $past(next_q.vec[s_idx]))
    else $error("full store lanes wrong");

  chk_csr_rsvd: assert property (@(posedge clk_i)
    disable iff (sys_rst_i)
    csr_wr_i && csr_wr_data_i[wsvrf_pkg::CSR_W-1:wsvrf_pkg::CSR_RSVD_LO]
    != '0 |=> gp_fault_o &&
      csr_o[wsvrf_pkg::CSR_W-1:wsvrf_pkg::CSR_RSVD_LO] == '0)
    else $error("reserved control bits accepted");

  chk_flag_sticky: assert property (@(posedge clk_i)
    disable iff (sys_rst_i)
    fp_flags_set_i != '0 |=>
      (csr_o[wsvrf_pkg::CSR_FLAG_W-1:0] & $past(fp_flags_set_i)) ==
      $past(fp_flags_set_i))
    else $error("status flag set lost");

  chk_cmp_flags: assert property (@(posedge clk_i)
    disable iff (sys_rst_i)
    cmp_valid_i |=> flags_o[wsvrf_pkg::FLG_ZF] == $past(cmp_zf_i) &&
      flags_o[wsvrf_pkg::FLG_CF] == $past(cmp_cf_i) &&
      !flags_o[wsvrf_pkg::FLG_OF])
    else $error("compare flags wrong");

  chk_width_bit: assert property (@(posedge clk_i)
    disable iff (sys_rst_i)
    mode_i != wsvrf_pkg::WSVRF_LONG64 |=> !gpr_w64_o)
    else $error("width bit honoured outside 64-bit mode");

  cov_fwd: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    wr_en_i && a_idx == w_idx && b_idx == w_idx);
  cov_upper: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    wr_en_i && w_idx[wsvrf_pkg::IDX_W-1]);
  cov_fault: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    gp_fault_o);
  cov_store: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    st_req_i ##1 st_valid_o);

endmodule

/* dv/wsvrf_exec_model.sv */
// Execution unit stand-in: scalar compare on the low lanes
`timescale 1ns/1ps
module wsvrf_exec_model (
  input  wire logic        clk_i,
  input  wire logic        go_i,
  input  wire logic [31:0] a_i,
  input  wire logic [31:0] b_i,
  output logic             cmp_valid_o,
  output logic             zf_o,
  output logic             pf_o,
  output logic             cf_o
);
  // Known levels from time zero; one process drives each
  logic [2:0] res  = '0;
  logic       pend = 1'b0;
  logic [3:0] outq = '0;

  // Request and operands taken on the rising edge, when stable
  always @(posedge clk_i) begin
    pend <= go_i;
    res  <= {a_i == b_i, 1'b0, a_i < b_i};
  end
  // Outside a result the bits toggle, so unqualified use shows up
  always @(negedge clk_i) begin
    outq[3]   <= pend;
    outq[2:0] <= pend ? res : ~outq[2:0];
  end
  assign {cmp_valid_o, zf_o, pf_o, cf_o} = outq;
endmodule

/* dv/tb_wide_simd_vector_register_file.sv */
// Self-checking bench for the wide vector register file
`timescale 1ns/1ps
module tb_wide_simd_vector_register_file;
  logic         clk_i, sys_rst_i, rex_i, operand_width_prefix_bit_i, go;
  logic         rd_a_ext_i, rd_b_ext_i, wr_en_i, wr_ext_i, st_ext_i;
  logic         wr_zero_upper_i, wr_src_mm_i, st_req_i, mm_wr_i;
  logic         csr_wr_i, feat_req_i, st_valid_o, gp_fault_o, gpr_w64_o;
  logic         cmp_valid_i, cmp_zf_i, cmp_pf_i, cmp_cf_i;
  logic [2:0]   rd_a_sel_i, rd_b_sel_i, wr_sel_i, st_sel_i, mm_sel_i;
  logic [127:0] wr_data_i, rd_a_o, rd_b_o, st_data_o, mv[16];
  logic [63:0]  ea_base_i, ea_index_i, ea_o, mm[8];
  logic [31:0]  csr_wr_data_i, csr_o, flags_o, feat_leaf_i, feat_d_o;
  logic [31:0]  ea_disp_i, seed, csr_m, flg_m;
  logic [15:0]  st_be_o;
  logic [5:0]   fp_flags_set_i;
  logic [1:0]   ea_scale_i;
  int           n_fail = 0;
  int           checked = 0;
  int           ia, ib;
  wsvrf_pkg::wsvrf_mode_type mode_i;
  wsvrf_pkg::wsvrf_size_type wr_size_i, st_size_i;

  wsvrf_top dut (.*);
  wsvrf_exec_model partner (
    .clk_i, .go_i(go), .a_i(rd_a_o[31:0]), .b_i(rd_b_o[31:0]),
    .cmp_valid_o(cmp_valid_i), .zf_o(cmp_zf_i), .pf_o(cmp_pf_i),
    .cf_o(cmp_cf_i));

  // 20 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // Xorshift source, seeded with one
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Upper index only counts in 64-bit mode with the prefix
  function automatic int ix(input logic [2:0] s, input logic e);
    return (mode_i == wsvrf_pkg::WSVRF_LONG64 && rex_i && e) ? 8 + s : s;
  endfunction

  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Write, read a and a store of the same register in one cycle, plus read b
  task automatic op(input logic we, input logic [2:0] s, input logic e,
                    input wsvrf_pkg::wsvrf_size_type sz, input logic zu);
    logic [127:0] d, m;
    logic [15:0]  be;
    logic [2:0]   bs;
    logic [63:0]  ea_x;
    d = {rnd(), rnd(), rnd(), rnd()};
    // Port b reads the written register or its neighbour
    bs = s + 3'(rnd() % 2);
    be = (sz == wsvrf_pkg::WSVRF_SZ32) ? 16'h000F :
         (sz == wsvrf_pkg::WSVRF_SZ64) ? 16'h00FF : 16'hFFFF;
    for (int i = 0; i < 128; i++) m[i] = be[i / 8];
    wr_en_i = we;
    wr_sel_i = s;
    wr_ext_i = e;
    wr_size_i = sz;
    wr_zero_upper_i = zu;
    wr_data_i = d;
    {rd_a_sel_i, rd_b_sel_i, st_sel_i} = {s, bs, s};
    {rd_a_ext_i, rd_b_ext_i, st_ext_i, st_req_i} = {e, e, e, 1'b1};
    st_size_i = sz;
    {ea_base_i, ea_index_i} = {rnd(), rnd(), rnd(), rnd()};
    ea_scale_i = 2'(rnd());
    ea_disp_i = rnd();
    // Address wraps at 64 bits, as the general registers do
    ea_x = ea_base_i + (ea_index_i << ea_scale_i) +
           {{32{ea_disp_i[31]}}, ea_disp_i};
    if (wr_src_mm_i) d = {64'h0, mm[mm_sel_i]};
    ia = ix(s, e);
    ib = ix(bs, e);
    if (we) mv[ia] = (d & m) | (zu ? 128'h0 : mv[ia] & ~m);
    @(negedge clk_i);
    chk(rd_a_o, mv[ia]);
    chk(rd_b_o, mv[ib]);
    chk({st_valid_o, st_be_o}, {1'b1, be});
    chk(st_data_o & m, mv[ia] & m);
    chk(gpr_w64_o, ix(3'h0, operand_width_prefix_bit_i) == 8);
    chk(ea_o, ea_x);
  endtask

  // Store pulse must fall once requests stop
  task automatic idle();
    {wr_en_i, st_req_i} = 2'h0;
    @(negedge clk_i);
    chk(st_valid_o, 1'b0);
  endtask

  // Low half of a vector register into a packed-integer register
  task automatic mmv(input logic [2:0] s, input logic [2:0] k);
    {rd_a_sel_i, rd_a_ext_i, mm_sel_i, mm_wr_i} = {s, 1'b1, k, 1'b1};
    mm[k] = mv[ix(s, 1'b1)][63:0];
    @(negedge clk_i);
    mm_wr_i = 1'b0;
  endtask

  // Control load racing sticky flag sets
  task automatic csr(input logic [31:0] v);
    {csr_wr_i, csr_wr_data_i, fp_flags_set_i} = {1'b1, v, 6'(rnd())};
    csr_m = ((v[31:16] == 16'h0) ? v : csr_m) | {26'h0, fp_flags_set_i};
    @(negedge clk_i);
    chk(csr_o, csr_m);
    chk(gp_fault_o, v[31:16] != 16'h0);
    {csr_wr_i, fp_flags_set_i} = 7'h0;
  endtask

  // Compare through the partner; expected from the model registers
  task automatic cmp();
    go = 1'b1;
    @(negedge clk_i);
    go = 1'b0;
    @(negedge clk_i);
    flg_m = flg_m & ~32'h0000_08D5;
    flg_m[wsvrf_pkg::FLG_ZF] = mv[ia][31:0] == mv[ib][31:0];
    flg_m[wsvrf_pkg::FLG_CF] = mv[ia][31:0] < mv[ib][31:0];
    chk(flags_o, flg_m);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Tests need about 91 cycles; this cuts a hang at 3000
  initial begin
    #(50 * 3000);
    n_fail++;
    print_verdict();
  end

  initial begin
    {rex_i, operand_width_prefix_bit_i, rd_a_ext_i, rd_b_ext_i, wr_en_i, wr_ext_i, st_ext_i,
     wr_zero_upper_i, wr_src_mm_i, st_req_i, mm_wr_i, csr_wr_i, feat_req_i,
     go, rd_a_sel_i, rd_b_sel_i, wr_sel_i, st_sel_i, mm_sel_i, wr_data_i,
     ea_base_i, ea_index_i, ea_scale_i, ea_disp_i, csr_wr_data_i,
     feat_leaf_i, fp_flags_set_i} = '0;
    mode_i = wsvrf_pkg::WSVRF_REAL;
    wr_size_i = wsvrf_pkg::WSVRF_SZ32;
    st_size_i = wsvrf_pkg::WSVRF_SZ32;
    foreach (mv[i]) mv[i] = '0;
    foreach (mm[i]) mm[i] = '0;
    {seed, csr_m, flg_m} = {32'h1, 32'h0000_1F80, 32'h0000_0002};
    sys_rst_i = 1'b1;
    repeat (12) @(negedge clk_i);
    chk(csr_o, csr_m);
    chk(flags_o, flg_m);
    sys_rst_i = 1'b0;
    // Every mode, with and without the prefix
    for (int md = 0; md < 5; md++) begin
      for (int r = 0; r < 2; r++) begin
        mode_i = wsvrf_pkg::wsvrf_mode_type'(md);
        {rex_i, operand_width_prefix_bit_i} = {r[0], 1'(rnd())};
        repeat (4) op(1'b1, 3'(rnd()), 1'(rnd()),
                      wsvrf_pkg::wsvrf_size_type'(rnd() % 3), 1'(rnd()));
      end
    end
    idle();
    $display("test modes done");
    // Packed-integer path, then equal compare
    {mode_i, rex_i} = {wsvrf_pkg::WSVRF_LONG64, 1'b1};
    mmv(3'h5, 3'h6);
    wr_src_mm_i = 1'b1;
    op(1'b1, 3'h0, 1'b0, wsvrf_pkg::WSVRF_SZ128, 1'b1);
    op(1'b1, 3'h1, 1'b0, wsvrf_pkg::WSVRF_SZ128, 1'b1);
    wr_src_mm_i = 1'b0;
    op(1'b0, 3'h0, 1'b0, wsvrf_pkg::WSVRF_SZ128, 1'b0);
    idle();
    cmp();
    // All sixteen read back untouched by the other files
    for (int i = 0; i < 16; i++) begin
      op(1'b0, 3'(i), 1'(i >> 3), wsvrf_pkg::WSVRF_SZ128, 1'b0);
    end
    idle();
    cmp();
    $display("test moves and compares done");
    repeat (3) begin
      csr({16'h0, 16'(rnd())});
      csr(32'h1 << (16 + rnd() % 16));
    end
    csr(32'h8000_0000);
    @(negedge clk_i);
    chk(gp_fault_o, 1'b0);
    $display("test control loads done");
    for (int i = 0; i < 4; i++) begin
      feat_req_i = 1'b1;
      feat_leaf_i = (i == 3) ? rnd() : i;
      @(negedge clk_i);
      chk(feat_d_o, (feat_leaf_i == 32'h1) ? 32'h0200_0000 : 32'h0);
    end
    feat_req_i = 1'b0;
    $display("test feature leaf done");
    print_verdict();
  end
endmodule
